// *** logic/adts_selector.sv ***
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "adts_defs.svh"
// Function
// - four time pairs, pair one default
// - accel time spans zero to maximum
// - decel time spans maximum to zero
// - two select bits choose pairs one-four
// - motor select input, not for PM
// - motor one: bit one picks pair 1/2
// - motor two: bit one picks pair 3/4
// - nonzero level: below pair4, else pair1
// - motor two level switching: pair 4/3
// - select inputs override level switching
// - zero level disables level switching
// - fast stop input 21/22 is latched
// - fast stop uses dedicated decel time
// - restart locked until stop, release, rerun
// - output code 44 during fast stop
// - unit 0 means 0.01 s steps
// - unit 1 default means 0.1 s steps
// - refuse unit 0 when time >= 600.1 s
// - PM closed loop level is percent
// - overvoltage fault cuts output, coasts
module adts_selector #(
   parameter int STEP_CYC = `ADTS_STEP_CYC,
   parameter int N_IN = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire adts_pkg::adts_wb_req_t wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [N_IN-1:0] din,
   input wire logic run_cmd,
   input wire logic ov_detect,
   output logic dout,
   output logic [15:0] out_freq,
   output logic drive_on
);
   // ============================================================
   // input synchronisers
   logic [N_IN+1:0] sync1_r, sync2_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (ce) begin
         sync1_r <= {ov_detect, run_cmd, din};
         sync2_r <= sync1_r;
      end
   end
   logic [N_IN-1:0] din_s;
   logic run_s, ov_s;
   assign din_s = sync2_r[N_IN-1:0];
   assign run_s = sync2_r[N_IN];
   assign ov_s = sync2_r[N_IN+1];

   // ============================================================
   // register file
   logic [15:0] time_r [0:8];
   logic [15:0] time_nxt [0:8];
   logic unit_r, unit_nxt;
   logic [15:0] level_r, level_nxt, fmax1_r, fmax1_nxt, fmax2_r, fmax2_nxt, cmd_r, cmd_nxt;
   logic [31:0] in_asg_r, in_asg_nxt;
   logic [7:0] out_asg_r, out_asg_nxt;
   logic pm_r, pm_nxt, pm_cl_r, pm_cl_nxt;
   logic ov_clr_nxt, ov_clr_r, flt_stop_nxt, flt_stop_r;
   logic ack_nxt;
   logic [31:0] rd_nxt;
   logic bus_wr;
   adts_pkg::adts_status_t stat;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            old[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return old;
   endfunction

   // true when a time reg address is hit; the caller computes idx itself
   function automatic logic time_hit(input logic [7:0] a);
      return a >= `ADTS_OFF_TIME0 && a <= `ADTS_OFF_TIME8 && a[1:0] == 2'b00;
   endfunction

   logic too_long;
   always_comb begin
      too_long = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (time_r[i] >= `ADTS_UNIT0_LIMIT) begin
            too_long = 1'b1;
         end
      end
   end

   assign bus_wr = wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack_o;

   always_comb begin
      logic [31:0] w;
      logic [3:0] idx;
      w = 32'h0;
      idx = 4'h0;
      for (int i = 0; i < 9; i++) begin
         time_nxt[i] = time_r[i];
      end
      unit_nxt = unit_r;
      level_nxt = level_r;
      fmax1_nxt = fmax1_r;
      fmax2_nxt = fmax2_r;
      cmd_nxt = cmd_r;
      in_asg_nxt = in_asg_r;
      out_asg_nxt = out_asg_r;
      pm_nxt = pm_r;
      pm_cl_nxt = pm_cl_r;
      ov_clr_nxt = 1'b0;
      flt_stop_nxt = 1'b0;
      ack_nxt = wb_req.cyc && wb_req.stb && !wb_ack_o;
      rd_nxt = 32'h0;
      if (time_hit(wb_req.adr)) begin
         idx = 4'((wb_req.adr - `ADTS_OFF_TIME0) >> 2);
      end
      if (bus_wr) begin
         if (time_hit(wb_req.adr)) begin
            w = merge({16'h0, time_r[idx]}, wb_req.dat, wb_req.sel);
            time_nxt[idx] = w[15:0];
         end
         unique case (wb_req.adr)
            `ADTS_OFF_CTRL: begin
               w = merge({28'h0, flt_stop_r, ov_clr_r, pm_cl_r, pm_r}, wb_req.dat, wb_req.sel);
               pm_nxt = w[`ADTS_CTRL_PM];
               pm_cl_nxt = w[`ADTS_CTRL_PM_CL];
               ov_clr_nxt = w[`ADTS_CTRL_OV_CLR];
               flt_stop_nxt = w[`ADTS_CTRL_FLT_STOP];
            end
            `ADTS_OFF_UNIT: begin
               // going to 0.01 s steps would truncate stored times above 600.0 s
               if (wb_req.sel[0] && (wb_req.dat[0] || !too_long)) begin
                  unit_nxt = wb_req.dat[0];
               end
            end
            `ADTS_OFF_LEVEL: begin
               w = merge({16'h0, level_r}, wb_req.dat, wb_req.sel);
               level_nxt = w[15:0];
            end
            `ADTS_OFF_FMAX1: begin
               w = merge({16'h0, fmax1_r}, wb_req.dat, wb_req.sel);
               fmax1_nxt = w[15:0];
            end
            `ADTS_OFF_FMAX2: begin
               w = merge({16'h0, fmax2_r}, wb_req.dat, wb_req.sel);
               fmax2_nxt = w[15:0];
            end
            `ADTS_OFF_IN_ASSIGN: in_asg_nxt = merge(in_asg_r, wb_req.dat, wb_req.sel);
            `ADTS_OFF_OUT_ASSIGN: begin
               w = merge({24'h0, out_asg_r}, wb_req.dat, wb_req.sel);
               out_asg_nxt = w[7:0];
            end
            `ADTS_OFF_FREQ_CMD: begin
               w = merge({16'h0, cmd_r}, wb_req.dat, wb_req.sel);
               cmd_nxt = w[15:0];
            end
            default: begin
            end
         endcase
      end
      if (time_hit(wb_req.adr)) begin
         rd_nxt = {16'h0, time_r[idx]};
      end else begin
         unique case (wb_req.adr)
            `ADTS_OFF_CTRL: rd_nxt = {30'h0, pm_cl_r, pm_r};
            `ADTS_OFF_UNIT: rd_nxt = {31'h0, unit_r};
            `ADTS_OFF_LEVEL: rd_nxt = {16'h0, level_r};
            `ADTS_OFF_FMAX1: rd_nxt = {16'h0, fmax1_r};
            `ADTS_OFF_FMAX2: rd_nxt = {16'h0, fmax2_r};
            `ADTS_OFF_IN_ASSIGN: rd_nxt = in_asg_r;
            `ADTS_OFF_OUT_ASSIGN: rd_nxt = {24'h0, out_asg_r};
            `ADTS_OFF_STATUS: rd_nxt = {10'h0, stat};
            `ADTS_OFF_FREQ_CMD: rd_nxt = {16'h0, cmd_r};
            default: rd_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < 9; i++) begin
            time_r[i] <= `ADTS_RST_TIME;
         end
         unit_r <= `ADTS_RST_UNIT;
         level_r <= 16'h0000;
         fmax1_r <= `ADTS_RST_FMAX;
         fmax2_r <= `ADTS_RST_FMAX;
         cmd_r <= 16'h0000;
         in_asg_r <= 32'h0;
         out_asg_r <= 8'h00;
         pm_r <= 1'b0;
         pm_cl_r <= 1'b0;
         ov_clr_r <= 1'b0;
         flt_stop_r <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce) begin
         for (int i = 0; i < 9; i++) begin
            time_r[i] <= time_nxt[i];
         end
         unit_r <= unit_nxt;
         level_r <= level_nxt;
         fmax1_r <= fmax1_nxt;
         fmax2_r <= fmax2_nxt;
         cmd_r <= cmd_nxt;
         in_asg_r <= in_asg_nxt;
         out_asg_r <= out_asg_nxt;
         pm_r <= pm_nxt;
         pm_cl_r <= pm_cl_nxt;
         ov_clr_r <= ov_clr_nxt;
         flt_stop_r <= flt_stop_nxt;
         wb_ack_o <= ack_nxt;
         wb_dat_o <= rd_nxt;
      end
   end

   // ============================================================
   // terminal decode and pair selection
   logic asg_sel1, asg_sel2, bit1, bit2, asg_m2, motor2, fs_trig, fs_held;
   always_comb begin
      asg_sel1 = 1'b0;
      asg_sel2 = 1'b0;
      asg_m2 = 1'b0;
      bit1 = 1'b0;
      bit2 = 1'b0;
      motor2 = 1'b0;
      fs_held = 1'b0;
      for (int i = 0; i < N_IN; i++) begin
         unique case (in_asg_r[i*8 +: 8])
            `ADTS_FN_SEL1: begin
               asg_sel1 = 1'b1;
               bit1 = bit1 | din_s[i];
            end
            `ADTS_FN_SEL2: begin
               asg_sel2 = 1'b1;
               bit2 = bit2 | din_s[i];
            end
            `ADTS_FN_MOTOR2: begin
               asg_m2 = 1'b1;
               motor2 = motor2 | (din_s[i] & !pm_r);
            end
            `ADTS_FN_FSTOP_NO: fs_held = fs_held | din_s[i];
            `ADTS_FN_FSTOP_NC: fs_held = fs_held | !din_s[i];
            default: begin
            end
         endcase
      end
      fs_trig = fs_held | flt_stop_r;
   end

   logic [15:0] fmax, freq_r, freq_nxt;
   logic below;
   logic [1:0] pair_r, pair_nxt;
   assign fmax = motor2 ? fmax2_r : fmax1_r;
   // percent compare done by cross multiplication to avoid a divider
   assign below = pm_cl_r ? (32'(freq_r) * 32'(`ADTS_PCT_FULL) < 32'(level_r) * 32'(fmax))
                          : (freq_r < level_r);

   always_comb begin
      if (asg_sel1 || asg_sel2) begin
         if (asg_m2 && motor2) begin
            pair_nxt = bit1 ? 2'h3 : 2'h2;
         end else if (asg_m2) begin
            pair_nxt = bit1 ? 2'h1 : 2'h0;
         end else begin
            pair_nxt = {bit2, bit1};
         end
      end else if (level_r != 16'h0000) begin
         pair_nxt = below ? 2'h3 : (motor2 ? 2'h2 : 2'h0);
      end else begin
         pair_nxt = motor2 ? 2'h2 : 2'h0;
      end
   end

   // ============================================================
   // fast stop sequencing
   adts_pkg::adts_fs_t fs_r, fs_nxt;
   logic run_seen_low_r, run_seen_low_nxt;
   always_comb begin
      fs_nxt = fs_r;
      run_seen_low_nxt = run_seen_low_r;
      unique case (fs_r)
         adts_pkg::FS_RUN: if (fs_trig) fs_nxt = adts_pkg::FS_DECEL;
         adts_pkg::FS_DECEL: begin
            run_seen_low_nxt = 1'b0;
            if (freq_r == 16'h0000) fs_nxt = adts_pkg::FS_LOCK;
         end
         adts_pkg::FS_LOCK: begin
            if (!run_s) run_seen_low_nxt = 1'b1;
            // leave only once stopped, released and run dropped
            if (!fs_trig && (run_seen_low_r || !run_s)) fs_nxt = adts_pkg::FS_RUN;
         end
      endcase
   end

   // ============================================================
   // ramp generator
   logic [$clog2(STEP_CYC)-1:0] pre_r, pre_nxt;
   logic [3:0] dec_r, dec_nxt;
   logic [17:0] acc_r, acc_nxt;
   logic ov_r, ov_nxt, on_r, on_nxt, tick;
   logic [15:0] target, tsel;
   always_comb begin
      pre_nxt = pre_r + 1'b1;
      dec_nxt = dec_r;
      tick = 1'b0;
      if (pre_r == ($clog2(STEP_CYC))'(STEP_CYC - 1)) begin
         pre_nxt = '0;
         if (!unit_r) begin
            tick = 1'b1;
         end else if (dec_r == `ADTS_DECADE) begin
            dec_nxt = 4'h0;
            tick = 1'b1;
         end else begin
            dec_nxt = dec_r + 4'h1;
         end
      end
      // commands above the ceiling are clamped to it
      target = (fs_r == adts_pkg::FS_RUN && run_s && !ov_r) ? ((cmd_r > fmax) ? fmax : cmd_r) : 16'h0000;
      if (fs_r == adts_pkg::FS_DECEL) begin
         tsel = time_r[8];
      end else if (freq_r < target) begin
         tsel = time_r[{pair_r, 1'b0}];
      end else begin
         tsel = time_r[{pair_r, 1'b1}];
      end
      ov_nxt = ov_r;
      if (ov_clr_r) ov_nxt = 1'b0;
      if (ov_s && freq_r > target) ov_nxt = 1'b1;
      on_nxt = !ov_nxt && (freq_r != 16'h0000 || target != 16'h0000);
      freq_nxt = freq_r;
      acc_nxt = acc_r + (tick ? 18'(fmax) : 18'h0);
      if (ov_nxt) begin
         freq_nxt = 16'h0000;
         acc_nxt = 18'h0;
      end else if (freq_r == target) begin
         acc_nxt = 18'h0;
      end else if (tsel == 16'h0000) begin
         freq_nxt = target;
         acc_nxt = 18'h0;
      end else if (acc_r >= 18'(tsel)) begin
         freq_nxt = (freq_r < target) ? freq_r + 16'h1 : freq_r - 16'h1;
         acc_nxt = acc_nxt - 18'(tsel);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fs_r <= adts_pkg::FS_RUN;
         run_seen_low_r <= 1'b0;
         pair_r <= 2'h0;
         pre_r <= '0;
         dec_r <= 4'h0;
         acc_r <= 18'h0;
         freq_r <= 16'h0000;
         ov_r <= 1'b0;
         on_r <= 1'b0;
         dout <= 1'b0;
         out_freq <= 16'h0000;
         drive_on <= 1'b0;
      end else if (ce) begin
         fs_r <= fs_nxt;
         run_seen_low_r <= run_seen_low_nxt;
         pair_r <= pair_nxt;
         pre_r <= pre_nxt;
         dec_r <= dec_nxt;
         acc_r <= acc_nxt;
         freq_r <= freq_nxt;
         ov_r <= ov_nxt;
         on_r <= on_nxt;
         dout <= (out_asg_r == `ADTS_FN_DUR_FSTOP) && (fs_nxt == adts_pkg::FS_DECEL);
         out_freq <= freq_nxt;
         drive_on <= on_nxt;
      end
   end

   assign stat = '{freq: freq_r, pair: pair_r, fast_stop: fs_r == adts_pkg::FS_DECEL,
                   locked: fs_r == adts_pkg::FS_LOCK, ov_fault: ov_r, drive_on: on_r};

   // ============================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence fs_start_s;
      ce && fs_r == adts_pkg::FS_RUN && fs_trig;
   endsequence
   sequence fs_done_s;
      ce && fs_r == adts_pkg::FS_DECEL && freq_r == 16'h0000;
   endsequence
   ack_pulse_a: assert property (ce && wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   fs_latch_a: assert property (fs_start_s |=> fs_r == adts_pkg::FS_DECEL) else $error("fast stop missed");
   fs_lock_a: assert property (fs_done_s |=> fs_r == adts_pkg::FS_LOCK ##1 !drive_on || fs_r != adts_pkg::FS_LOCK) else $error("no lock");
   lock_hold_a: assert property (ce && fs_r == adts_pkg::FS_LOCK && fs_trig |=> fs_r == adts_pkg::FS_LOCK) else $error("lock left early");
   fs_term_a: assert property (ce && out_asg_r == `ADTS_FN_DUR_FSTOP && fs_nxt == adts_pkg::FS_DECEL |=> dout) else $error("terminal not set");
   unit_keep_a: assert property (bus_wr && ce && wb_req.adr == `ADTS_OFF_UNIT && too_long && unit_r |=> unit_r) else $error("unit 0 taken");
   pair_dflt_a: assert property (ce && !asg_sel1 && !asg_sel2 && !asg_m2 && level_r == 16'h0000 |=> pair_r == 2'h0) else $error("pair not one");
   ramp_step_a: assert property (ce && tsel != 16'h0000 && !ov_nxt |=> (freq_r - $past(freq_r) <= 16'h1) || ($past(freq_r) - freq_r <= 16'h1)) else $error("ramp jumped");
   ov_coast_a: assert property (ce && ov_r && !ov_clr_r |=> !drive_on && out_freq == 16'h0000) else $error("no coast");
endmodule

// *** logic/adts_defs.svh ***
`ifndef ADTS_DEFS_SVH
`define ADTS_DEFS_SVH
// register byte offsets
`define ADTS_OFF_CTRL       8'h00
`define ADTS_OFF_TIME0      8'h04
`define ADTS_OFF_TIME8      8'h24
`define ADTS_OFF_UNIT       8'h28
`define ADTS_OFF_LEVEL      8'h2c
`define ADTS_OFF_FMAX1      8'h30
`define ADTS_OFF_FMAX2      8'h34
`define ADTS_OFF_IN_ASSIGN  8'h38
`define ADTS_OFF_OUT_ASSIGN 8'h3c
`define ADTS_OFF_STATUS     8'h40
`define ADTS_OFF_FREQ_CMD   8'h44
// control fields
`define ADTS_CTRL_PM        0
`define ADTS_CTRL_PM_CL     1
`define ADTS_CTRL_OV_CLR    2
`define ADTS_CTRL_FLT_STOP  3
// terminal function codes
`define ADTS_FN_SEL1        8'h10
`define ADTS_FN_SEL2        8'h11
`define ADTS_FN_FSTOP_NO    8'h15
`define ADTS_FN_FSTOP_NC    8'h16
`define ADTS_FN_MOTOR2      8'h33
`define ADTS_FN_DUR_FSTOP   8'h2c
// reset values, times in 0.1 s units
`define ADTS_RST_TIME       16'h0064
`define ADTS_RST_UNIT       1'b1
`define ADTS_RST_FMAX       16'h0258
// unit 0 refused when any time reaches 600.1 s
`define ADTS_UNIT0_LIMIT    16'h1771
// percent scale of the switch level, 100.0 %
`define ADTS_PCT_FULL       16'h03e8
// base ramp step is 0.01 s
`define ADTS_STEP_NS        10000000
`define ADTS_CLK_NS         40
`define ADTS_STEP_CYC       (`ADTS_STEP_NS / `ADTS_CLK_NS)
`define ADTS_DECADE         4'h9
`endif

// *** logic/adts_pkg.sv ***
package adts_pkg;
   typedef enum logic [1:0] {FS_RUN, FS_DECEL, FS_LOCK} adts_fs_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } adts_wb_req_t;
   typedef struct packed {
      logic [15:0] freq;
      logic [1:0] pair;
      logic fast_stop;
      logic locked;
      logic ov_fault;
      logic drive_on;
   } adts_status_t;
endpackage

// *** testbench/adts_terminals.sv ***
`timescale 1ns/10ps
// ==========================================
// terminal bank: contacts and run switch
module adts_terminals (
   input wire logic clk,
   input wire logic [3:0] din_req,
   input wire logic run_req,
   input wire logic ov_req,
   output logic [3:0] din,
   output logic run_cmd,
   output logic ov_detect
);
   // contacts move just after an edge, never on the edge the drive samples
   always_ff @(posedge clk) begin
      din <= din_req;
      run_cmd <= run_req;
      ov_detect <= ov_req;
   end
endmodule

// *** testbench/accel_decel_time_selector_tb.sv ***
`timescale 1ns/10ps
`include "adts_defs.svh"
module accel_decel_time_selector_tb;
   logic clk;
   logic srst;
   adts_pkg::adts_wb_req_t wb_req;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] din;
   logic [3:0] din_req;
   logic run_cmd;
   logic run_req;
   logic ov_detect;
   logic ov_req;
   logic dout;
   logic [15:0] out_freq;
   logic drive_on;
   int errors = 0;
   int n_compared = 0;
   int n;

   adts_selector #(.STEP_CYC(10), .N_IN(4)) DUT (.clk(clk), .srst(srst), .ce(1'b1), .wb_req(wb_req),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din(din), .run_cmd(run_cmd), .ov_detect(ov_detect),
      .dout(dout), .out_freq(out_freq), .drive_on(drive_on));
   adts_terminals u_term (.clk(clk), .din_req(din_req), .run_req(run_req), .ov_req(ov_req), .din(din),
      .run_cmd(run_cmd), .ov_detect(ov_detect));

   // ==========================================
   // shared tasks
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // entered just after a rising edge; the request stands until the edge that sees ack high,
   // read data is taken at that edge, then cyc and stb stay low for one edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int i;
      i = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && i < 50) begin
         @(posedge clk);
         i++;
      end
      if (i >= 50) begin
         errors++;
         end_sim();
      end
      rd = wb_dat_o;
      wb_req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, adr, d, x);
   endtask

   task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      wb(1'b0, adr, 32'h0, x);
      check(what, x & m, e);
   endtask

   task automatic wait_freq(input logic [15:0] t, input int bound);
      n = 0;
      while (out_freq !== t && n < bound) begin
         @(posedge clk);
         n++;
      end
      if (n >= bound) begin
         errors++;
         $display("wrong value out_freq expected %h seen %h", t, out_freq);
         end_sim();
      end
   endtask

   task automatic rerun;
      run_req <= 1'b0;
      repeat (6) @(posedge clk);
      run_req <= 1'b1;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      end_sim();
   end

   // ==========================================
   // main sequence
   initial begin
      srst = 1'b1;
      wb_req = '0;
      din_req = 4'h0;
      run_req = 1'b0;
      ov_req = 1'b0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rdc("time0", `ADTS_OFF_TIME0, 32'hffff, 32'h64);
      rdc("unit", `ADTS_OFF_UNIT, 32'h1, 32'h1);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h0);
      rdc("unmapped", 8'h80, 32'hffffffff, 32'h0);
      $display("test reset done");
      // 600.1 s in tenths blocks the fine unit, 600.0 s does not
      wr(`ADTS_OFF_TIME0 + 8'h0c, 32'h1771);
      wr(`ADTS_OFF_UNIT, 32'h0);
      rdc("unit", `ADTS_OFF_UNIT, 32'h1, 32'h1);
      wr(`ADTS_OFF_TIME0 + 8'h0c, 32'h1770);
      wr(`ADTS_OFF_UNIT, 32'h0);
      rdc("unit", `ADTS_OFF_UNIT, 32'h1, 32'h0);
      $display("test unit done");
      wr(`ADTS_OFF_IN_ASSIGN, 32'h1110);
      for (int k = 0; k < 4; k++) begin
         din_req <= 4'(k);
         repeat (6) @(posedge clk);
         rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'(k) << 4);
      end
      wr(`ADTS_OFF_IN_ASSIGN, 32'h330010);
      for (int k = 0; k < 8; k++) begin
         wr(`ADTS_OFF_CTRL, 32'(k >> 2));
         din_req <= {1'b0, 1'(k >> 1), 1'b0, 1'(k)};
         repeat (6) @(posedge clk);
         rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'(k < 4 ? k : k & 1) << 4);
      end
      wr(`ADTS_OFF_CTRL, 32'h0);
      wr(`ADTS_OFF_IN_ASSIGN, 32'h0);
      din_req <= 4'h0;
      $display("test select done");
      // 100 counts of 0.01 s at 10 cycles a count: full scale takes 1000 cycles
      wr(`ADTS_OFF_FMAX1, 32'h64);
      wr(`ADTS_OFF_FREQ_CMD, 32'h64);
      run_req <= 1'b1;
      wait_freq(16'h64, 1200);
      check("accel cycles ok", n >= 950 && n <= 1050, 32'h1);
      wr(`ADTS_OFF_FREQ_CMD, 32'h0);
      wait_freq(16'h0, 1200);
      check("decel cycles ok", n >= 950 && n <= 1050, 32'h1);
      $display("test ramp done");
      wr(`ADTS_OFF_LEVEL, 32'h32);
      wr(`ADTS_OFF_FREQ_CMD, 32'h1e);
      wait_freq(16'h1e, 700);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h30);
      wr(`ADTS_OFF_FREQ_CMD, 32'h32);
      wait_freq(16'h32, 700);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h00);
      wr(`ADTS_OFF_IN_ASSIGN, 32'h330000);
      din_req <= 4'h4;
      repeat (6) @(posedge clk);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h20);
      wr(`ADTS_OFF_FREQ_CMD, 32'h1e);
      wait_freq(16'h1e, 700);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h30);
      din_req <= 4'h0;
      wr(`ADTS_OFF_IN_ASSIGN, 32'h1110);
      repeat (6) @(posedge clk);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h00);
      wr(`ADTS_OFF_IN_ASSIGN, 32'h0);
      // percent level at 30 of 100 counts: 20.0 % is passed, 40.0 % is not
      wr(`ADTS_OFF_CTRL, 32'h2);
      wr(`ADTS_OFF_LEVEL, 32'hc8);
      rdc("pair pct", `ADTS_OFF_STATUS, 32'h30, 32'h00);
      wr(`ADTS_OFF_LEVEL, 32'h190);
      rdc("pair pct", `ADTS_OFF_STATUS, 32'h30, 32'h30);
      wr(`ADTS_OFF_CTRL, 32'h0);
      wr(`ADTS_OFF_LEVEL, 32'h0);
      rdc("pair", `ADTS_OFF_STATUS, 32'h30, 32'h00);
      $display("test level done");
      // 20 counts a full scale: 80 of 100 counts take 16 ticks, 160 cycles
      wr(`ADTS_OFF_TIME8, 32'h14);
      wr(`ADTS_OFF_OUT_ASSIGN, 32'h2c);
      wr(`ADTS_OFF_IN_ASSIGN, 32'h15000000);
      wr(`ADTS_OFF_FREQ_CMD, 32'h50);
      wait_freq(16'h50, 700);
      din_req <= 4'h8;
      repeat (2) @(posedge clk);
      din_req <= 4'h0;
      repeat (8) @(posedge clk);
      check("dout", dout, 32'h1);
      wait_freq(16'h0, 250);
      check("stop cycles ok", n >= 140 && n <= 170, 32'h1);
      repeat (200) @(posedge clk);
      check("dout", dout, 32'h0);
      check("freq", out_freq, 32'h0);
      rdc("locked", `ADTS_OFF_STATUS, 32'h4, 32'h4);
      rerun();
      wait_freq(16'h50, 900);
      // normally closed contact: a closed circuit must not stop, opening it is the stop request
      wr(`ADTS_OFF_IN_ASSIGN, 32'h0);
      din_req <= 4'h8;
      repeat (6) @(posedge clk);
      wr(`ADTS_OFF_IN_ASSIGN, 32'h16000000);
      rdc("closed nc", `ADTS_OFF_STATUS, 32'h8, 32'h0);
      din_req <= 4'h0;
      repeat (8) @(posedge clk);
      check("dout nc", dout, 32'h1);
      din_req <= 4'h8;
      wait_freq(16'h0, 250);
      rerun();
      wait_freq(16'h50, 900);
      wr(`ADTS_OFF_CTRL, 32'h8);
      rdc("fault stop", `ADTS_OFF_STATUS, 32'h8, 32'h8);
      wait_freq(16'h0, 250);
      check("fault stop cycles ok", n >= 140 && n <= 170, 32'h1);
      rerun();
      wait_freq(16'h50, 900);
      $display("test fast stop done");
      wr(`ADTS_OFF_FREQ_CMD, 32'h0);
      ov_req <= 1'b1;
      repeat (8) @(posedge clk);
      check("drive_on", drive_on, 32'h0);
      check("coast", out_freq, 32'h0);
      ov_req <= 1'b0;
      rdc("ov", `ADTS_OFF_STATUS, 32'h2, 32'h2);
      wr(`ADTS_OFF_CTRL, 32'h4);
      rdc("ov", `ADTS_OFF_STATUS, 32'h2, 32'h0);
      $display("test overvoltage done");
      end_sim();
   end
endmodule
